// file: rtl/conversion_clock_select_defines.vh
/*
 Constants for the converter sequencer: register byte offsets, field positions,
 reset values and timing counts.
 Assumes a 10 MHz system clock and 32-bit AXI4-Lite register access.
*/
`ifndef CONVERSION_CLOCK_SELECT_DEFINES_VH
`define CONVERSION_CLOCK_SELECT_DEFINES_VH

// Register byte offsets.
`define CONVERSION_CLOCK_SELECT_OFF_CTRL        8'h00
`define CONVERSION_CLOCK_SELECT_OFF_TIMING      8'h04
`define CONVERSION_CLOCK_SELECT_OFF_RESULT      8'h08
`define CONVERSION_CLOCK_SELECT_OFF_STATUS      8'h0c
`define CONVERSION_CLOCK_SELECT_OFF_MASK        8'h10
`define CONVERSION_CLOCK_SELECT_OFF_PINCFG      8'h14
`define CONVERSION_CLOCK_SELECT_OFF_PORT        8'h18

// Control register fields.
`define CONVERSION_CLOCK_SELECT_CTRL_GO         0
`define CONVERSION_CLOCK_SELECT_CTRL_CHAN_LSB   4
`define CONVERSION_CLOCK_SELECT_CTRL_CHAN_MSB   7

// Timing register fields.
`define CONVERSION_CLOCK_SELECT_TIM_CLK_LSB     0
`define CONVERSION_CLOCK_SELECT_TIM_CLK_MSB     2
`define CONVERSION_CLOCK_SELECT_TIM_ACQ_LSB     3
`define CONVERSION_CLOCK_SELECT_TIM_ACQ_MSB     5

// Status bit positions.
`define CONVERSION_CLOCK_SELECT_ST_DONE         0

// Reset values.
`define CONVERSION_CLOCK_SELECT_RST_TIMING      6'h00
`define CONVERSION_CLOCK_SELECT_RST_MASK        1'b0
`define CONVERSION_CLOCK_SELECT_RST_PINCFG      16'h0000

// Bit periods per 10-bit conversion.
`define CONVERSION_CLOCK_SELECT_BITS_PER_CONV   4'hb

// Internal RC bit period in nanoseconds and system clock period in nanoseconds.
`define CONVERSION_CLOCK_SELECT_RC_PERIOD_NS    4000
`define CONVERSION_CLOCK_SELECT_CLK_PERIOD_NS   100

`endif

// file: rtl/conversion_clock_select_tick_gen.v
/*
 Bit-period tick generator: emits a one-cycle tick at the end of each period.
 Assumes the reload value is held steady while enabled; restart clears the count.
*/
`timescale 1ns/10ps
`default_nettype none

module conversion_clock_select_tick_gen #(
   parameter WIDTH = 8
) (
   // Clock and reset.
   input  wire             ref_clk_i,
   input  wire             resetn_i,
   // Control.
   input  wire             run_i,
   input  wire [WIDTH-1:0] period_i,
   // Tick output.
   output wire             tick_o
);

   reg [WIDTH-1:0] cnt_reg;

   // Tick when the count reaches the last cycle of the period.
   assign tick_o = run_i && (cnt_reg == period_i - {{(WIDTH-1){1'b0}}, 1'b1});

   // Free count while running, cleared when stopped.
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         cnt_reg <= {WIDTH{1'b0}};
      else if (!run_i || tick_o)
         cnt_reg <= {WIDTH{1'b0}};
      else
         cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
   end

endmodule
`default_nettype wire

// file: rtl/conversion_clock_select_sequencer.v
/*
 Acquisition and conversion sequencer of a 10-bit successive-approximation
 converter, with an AXI4-Lite register slave and a done interrupt.
 Assumes the comparator output is synchronous to ref_clk_i and that the analog
 front end samples while sample_o is high.
*/
`timescale 1ns/10ps
`default_nettype none
`include "conversion_clock_select_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: Acquisition select zero: go starts conversion at once, no added delay.
// R2: Acquisition select is timing bits 5:3, reset zero.
// R3: Nonzero select: keep sampling the programmed time, then convert automatically.
// R4: Conversion end clears go, sets done flag, resumes sampling selected channel.
// R5: No status tells acquisition apart from conversion.
// R6: A conversion lasts exactly 11 bit periods.
// R7: Clock select: 000/100/001/101/010/110 give 2..64 clocks, x11 internal RC.
// R8: Software keeps the oscillator within each divider's maximum frequency.
// R9: Software picks the shortest bit period above the minimum.
// R10: RC source gives a typical 4 us bit period, independent of oscillator; the code counts 40 system clocks, so it follows the oscillator.
// R11: Above 1 MHz with RC clock, software sleeps through the conversion.
// R12: Port reads return zero on pins configured analog.
// R13: Sequencing ignores channel select and direction bits.
// R14: Output-configured selected pin converts its own driven level.
// R15: Software sets direction to input for analog pins.
// R16: With zero acquisition, software waits acquisition time before go.
// R17: Nonzero acquisition codes map to bit-period counts via a parameter table.
// R18: Go set while busy is ignored; clearing go aborts and resumes sampling.
module conversion_clock_select_sequencer #(
   parameter       NPINS    = 16,
   parameter [20:0] ACQ_TABLE = {3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd6, 3'd7}
) (
   // Clock and reset.
   input  wire             ref_clk_i,
   input  wire             resetn_i,
   // AXI4-Lite write address and data.
   input  wire [7:0]       s_axi_awaddr,
   input  wire             s_axi_awvalid,
   output wire             s_axi_awready,
   input  wire [31:0]      s_axi_wdata,
   input  wire [3:0]       s_axi_wstrb,
   input  wire             s_axi_wvalid,
   output wire             s_axi_wready,
   // AXI4-Lite write response.
   output reg  [1:0]       s_axi_bresp,
   output reg              s_axi_bvalid,
   input  wire             s_axi_bready,
   // AXI4-Lite read.
   input  wire [7:0]       s_axi_araddr,
   input  wire             s_axi_arvalid,
   output wire             s_axi_arready,
   output reg  [31:0]      s_axi_rdata,
   output reg  [1:0]       s_axi_rresp,
   output reg              s_axi_rvalid,
   input  wire             s_axi_rready,
   // Analog front end.
   input  wire             comp_i,
   output reg              sample_o,
   output reg  [3:0]       channel_o,
   output reg  [9:0]       dac_o,
   // Port pins.
   input  wire [NPINS-1:0] pin_level_i,
   // Interrupt.
   output wire             irq_o
);

   localparam ST_SAMPLE = 2'd0;
   localparam ST_ACQ    = 2'd1;
   localparam ST_CONV   = 2'd2;
   localparam RC_CYC    = `CONVERSION_CLOCK_SELECT_RC_PERIOD_NS / `CONVERSION_CLOCK_SELECT_CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   reg  [1:0]       state_reg;
   reg              go_reg;
   reg  [3:0]       chan_reg;
   reg  [5:0]       timing_reg;
   reg  [9:0]       result_reg;
   reg  [9:0]       sar_reg;
   reg  [3:0]       bit_cnt_reg;
   reg  [2:0]       acq_cnt_reg;
   reg              done_reg;
   reg              mask_reg;
   reg  [NPINS-1:0] pincfg_reg;
   reg              aw_hold_reg;
   reg  [7:0]       aw_addr_reg;
   reg              w_hold_reg;
   reg  [31:0]      w_data_reg;
   reg  [3:0]       w_strb_reg;
   reg  [7:0]       tad_period;
   wire             tick;
   wire [2:0]       clk_sel = timing_reg[`CONVERSION_CLOCK_SELECT_TIM_CLK_MSB:`CONVERSION_CLOCK_SELECT_TIM_CLK_LSB];
   wire [2:0]       acq_sel = timing_reg[`CONVERSION_CLOCK_SELECT_TIM_ACQ_MSB:`CONVERSION_CLOCK_SELECT_TIM_ACQ_LSB];
   wire [2:0]       acq_len = ACQ_TABLE[(3'd7 - acq_sel) * 3 +: 3];

   ////////////////////////////////////////////////////////////////////////////
   // Bit period in system clocks from the clock select field.
   always @*
   begin
      case (clk_sel)
         3'b000:  tad_period = 8'h02; // R7
         3'b100:  tad_period = 8'h04;
         3'b001:  tad_period = 8'h08;
         3'b101:  tad_period = 8'h10;
         3'b010:  tad_period = 8'h20;
         3'b110:  tad_period = 8'h40;
         default: tad_period = RC_CYC[7:0]; // R10
      endcase
   end

   // Bit-period ticks run only while acquiring or converting.
   conversion_clock_select_tick_gen #(
      .WIDTH     (8)
   ) conversion_clock_select_tick_gen_inst (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .run_i     (state_reg != ST_SAMPLE),
      .period_i  (tad_period),
      .tick_o    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshakes: address and data are taken in either order.
   wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready  = !w_hold_reg;
   assign s_axi_arready = !s_axi_rvalid;
   wire wr_ctrl  = do_write && aw_addr_reg == `CONVERSION_CLOCK_SELECT_OFF_CTRL && w_strb_reg[0];
   wire go_write = wr_ctrl && w_data_reg[`CONVERSION_CLOCK_SELECT_CTRL_GO];
   wire go_clear = wr_ctrl && !w_data_reg[`CONVERSION_CLOCK_SELECT_CTRL_GO];
   wire conv_end = state_reg == ST_CONV && tick && bit_cnt_reg == `CONVERSION_CLOCK_SELECT_BITS_PER_CONV - 4'h1;

   // Capture of address and data beats, and the write response.
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         aw_hold_reg  <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_hold_reg   <= 1'b0;
         w_data_reg   <= 32'h00000000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end
      else
      begin
         if (s_axi_awvalid && !aw_hold_reg)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_reg)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg > `CONVERSION_CLOCK_SELECT_OFF_PORT || aw_addr_reg[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration registers written by software.
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         chan_reg   <= 4'h0;
         timing_reg <= `CONVERSION_CLOCK_SELECT_RST_TIMING; // R2
         mask_reg   <= `CONVERSION_CLOCK_SELECT_RST_MASK;
         pincfg_reg <= {NPINS{1'b0}};
      end
      else if (do_write)
      begin
         if (wr_ctrl)
            chan_reg <= w_data_reg[`CONVERSION_CLOCK_SELECT_CTRL_CHAN_MSB:`CONVERSION_CLOCK_SELECT_CTRL_CHAN_LSB];
         if (aw_addr_reg == `CONVERSION_CLOCK_SELECT_OFF_TIMING && w_strb_reg[0])
            timing_reg <= w_data_reg[5:0];
         if (aw_addr_reg == `CONVERSION_CLOCK_SELECT_OFF_MASK && w_strb_reg[0])
            mask_reg <= w_data_reg[`CONVERSION_CLOCK_SELECT_ST_DONE];
         if (aw_addr_reg == `CONVERSION_CLOCK_SELECT_OFF_PINCFG && w_strb_reg[0])
            pincfg_reg[7:0] <= w_data_reg[7:0];
         if (aw_addr_reg == `CONVERSION_CLOCK_SELECT_OFF_PINCFG && w_strb_reg[1])
            pincfg_reg[NPINS-1:8] <= w_data_reg[NPINS-1:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Acquisition and conversion sequence. Channel and pin direction play
   // no part in the flow; the front end converts whatever the pin shows.
   always @(posedge ref_clk_i or negedge resetn_i) // R13 R14
   begin
      if (!resetn_i)
      begin
         state_reg   <= ST_SAMPLE;
         go_reg      <= 1'b0;
         sar_reg     <= 10'h000;
         result_reg  <= 10'h000;
         bit_cnt_reg <= 4'h0;
         acq_cnt_reg <= 3'h0;
      end
      else
      begin
         case (state_reg)
            ST_SAMPLE:
            begin
               if (go_write) // R18
               begin
                  go_reg      <= 1'b1;
                  acq_cnt_reg <= 3'h0;
                  bit_cnt_reg <= 4'h0;
                  sar_reg     <= 10'h200;
                  if (acq_sel == 3'b000)
                     state_reg <= ST_CONV; // R1
                  else
                     state_reg <= ST_ACQ; // R3
               end
            end
            ST_ACQ:
            begin
               if (go_clear)
               begin
                  go_reg    <= 1'b0; // R18
                  state_reg <= ST_SAMPLE;
               end
               else if (tick)
               begin
                  acq_cnt_reg <= acq_cnt_reg + 3'h1;
                  if (acq_cnt_reg + 3'h1 >= acq_len) // R17
                     state_reg <= ST_CONV; // R3
               end
            end
            ST_CONV:
            begin
               if (go_clear)
               begin
                  go_reg    <= 1'b0; // R18
                  state_reg <= ST_SAMPLE;
               end
               else if (tick)
               begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1; // R6
                  if (bit_cnt_reg >= 4'h1 && bit_cnt_reg <= 4'ha)
                  begin
                     // One bit decided per period after the first.
                     sar_reg[4'ha - bit_cnt_reg] <= comp_i;
                     if (bit_cnt_reg != 4'ha)
                        sar_reg[4'h9 - bit_cnt_reg] <= 1'b1;
                  end
                  if (conv_end)
                  begin
                     go_reg     <= 1'b0; // R4
                     result_reg <= {sar_reg[9:1], comp_i}; // Last bit is decided at this edge.
                     state_reg  <= ST_SAMPLE;
                  end
               end
            end
            default:
               state_reg <= ST_SAMPLE;
         endcase
      end
   end

   // Front-end outputs: sampling resumes on the current channel when idle.
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sample_o  <= 1'b1;
         channel_o <= 4'h0;
         dac_o     <= 10'h000;
      end
      else
      begin
         sample_o  <= state_reg != ST_CONV; // R4
         channel_o <= chan_reg;
         dac_o     <= sar_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Done flag: set on conversion end wins over a write-one clear.
   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         done_reg <= 1'b0;
      else if (conv_end)
         done_reg <= 1'b1; // R4
      else if (do_write && aw_addr_reg == `CONVERSION_CLOCK_SELECT_OFF_STATUS && w_strb_reg[0] && w_data_reg[`CONVERSION_CLOCK_SELECT_ST_DONE])
         done_reg <= 1'b0;
   end

   assign irq_o = done_reg && mask_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read data mux; busy shows as go only, never the phase.
   wire [31:0] port_word = {{(32-NPINS){1'b0}}, pin_level_i & ~pincfg_reg}; // R12

   always @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'b00;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr)
            `CONVERSION_CLOCK_SELECT_OFF_CTRL:   s_axi_rdata <= {24'h000000, chan_reg, 3'b000, go_reg}; // R5
            `CONVERSION_CLOCK_SELECT_OFF_TIMING: s_axi_rdata <= {26'h0000000, timing_reg};
            `CONVERSION_CLOCK_SELECT_OFF_RESULT: s_axi_rdata <= {22'h000000, result_reg};
            `CONVERSION_CLOCK_SELECT_OFF_STATUS: s_axi_rdata <= {31'h00000000, done_reg};
            `CONVERSION_CLOCK_SELECT_OFF_MASK:   s_axi_rdata <= {31'h00000000, mask_reg};
            `CONVERSION_CLOCK_SELECT_OFF_PINCFG: s_axi_rdata <= {{(32-NPINS){1'b0}}, pincfg_reg};
            `CONVERSION_CLOCK_SELECT_OFF_PORT:   s_axi_rdata <= port_word;
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule
`default_nettype wire

// file: test/conversion_clock_select_checker.sv
/*
 Checker for the converter sequencer: bus handshakes, conversion and interrupt timing.
 Assumes it is bound to conversion_clock_select_sequencer and sees only the ports of that module.
*/
`timescale 1ns/10ps
`default_nettype none

module conversion_clock_select_checker (
   // Clock and reset.
   input wire logic        ref_clk_i,
   input wire logic        resetn_i,
   // Register bus.
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Front end and interrupt.
   input wire logic        sample_o,
   input wire logic        irq_o
);

////////////////////////////////////////////////////////////////////////////////
// One clock domain, so clocking and reset are declared once.
default clocking cb @(posedge ref_clk_i);
endclocking
default disable iff (!resetn_i);

// A write whose address and data are taken at one edge.
sequence wr_taken;
   s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence

// A conversion ends when sampling resumes.
sequence conv_stop;
   !sample_o ##1 sample_o;
endsequence

// Shortest conversion: 11 bit periods of two clocks each.
localparam int MIN_CONV = 22;

// Length of the current gap in sampling, and whether a write finished in it.
int unsigned low_len = 0;
logic        wr_seen = 1'b0;

always @(posedge ref_clk_i)
begin
   low_len <= sample_o ? 0 : low_len + 1;
   wr_seen <= sample_o ? 1'b0 : (wr_seen || s_axi_bvalid);
end

////////////////////////////////////////////////////////////////////////////////
// Handshake properties.
a_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
   else $error("write response missing");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
   else $error("read response missing");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
   else $error("write response dropped");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
   else $error("read data dropped");
a_arready_idle: assert property (s_axi_arready == !s_axi_rvalid)
   else $error("arready out of step");
a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
   else $error("bad write response code");

// A conversion lasts at least the shortest full length unless a write aborts it.
a_conv_min: assert property (conv_stop |-> low_len >= MIN_CONV || wr_seen)
   else $error("conversion ended early");

// The interrupt rises only with the end of a conversion or a register write.
a_irq_rise: assert property ($rose(irq_o) |-> ##1 ($rose(sample_o) || $past(s_axi_bvalid)))
   else $error("interrupt rose without cause");
a_irq_fall: assert property ($fell(irq_o) |-> s_axi_bvalid)
   else $error("interrupt fell without write");

endmodule

bind conversion_clock_select_sequencer conversion_clock_select_checker conversion_clock_select_checker_inst (.ref_clk_i, .resetn_i, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sample_o, .irq_o);

`default_nettype wire

// file: test/conversion_clock_select_sequencer_test.sv
/*
 Self-checking bench for the converter sequencer over AXI4-Lite.
 Assumes a 10 MHz clock and the default acquisition table (code n is n bit periods).
*/
`timescale 1ns/10ps
`default_nettype none
`include "conversion_clock_select_defines.vh"

module conversion_clock_select_sequencer_test;
   logic        ref_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, comp_i = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [15:0] pin_level_i = 16'h0000;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        sample_o, irq_o, s_prev;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata;
   logic [3:0]  channel_o;
   logic [9:0]  dac_o;
   int          err_count = 0, tests_run = 0, cycles = 0;
   int          low_cnt = 0, last_low = 0, lead_cnt = 0, last_lead = 0, conv_cnt = 0;

   conversion_clock_select_sequencer conversion_clock_select_sequencer_inst (.ref_clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .comp_i, .sample_o, .channel_o, .dac_o, .pin_level_i, .irq_o);

////////////////////////////////////////////////////////////////////////////////
   // Clock of 100 ns period.
   always #50 ref_clk_i = ~ref_clk_i;

   // Measures sampling gaps and the delay from a write to the start of a conversion.
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (!sample_o) low_cnt++;
      if (sample_o && low_cnt != 0)
      begin
         last_low = low_cnt;
         low_cnt = 0;
         conv_cnt++;
      end
      if (s_prev && !sample_o) last_lead = lead_cnt;
      lead_cnt = (s_axi_wvalid && s_axi_wready) ? 0 : lead_cnt + 1;
      s_prev = sample_o;
      if (cycles == 20000)
      begin
         err_count++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (err_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Write cycle: address and data offered together, each released when taken.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge ref_clk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // Read cycle: data and response taken at the edge where rvalid is seen.
   task automatic axi_read(input logic [7:0] a);
      @(posedge ref_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge ref_clk_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Bit period in clocks for a clock-select code.
   function automatic int per(input int c);
      if (c % 4 == 3) return `CONVERSION_CLOCK_SELECT_RC_PERIOD_NS / `CONVERSION_CLOCK_SELECT_CLK_PERIOD_NS;
      return 2 << (2 * (c % 4) + c / 4);
   endfunction

   // Selects a channel, lets it settle, starts a conversion and waits for its end.
   task automatic convert(input int tim, input int chan);
      int n;
      axi_write(`CONVERSION_CLOCK_SELECT_OFF_TIMING, tim);
      axi_write(`CONVERSION_CLOCK_SELECT_OFF_CTRL, chan << 4);
      repeat (8) @(posedge ref_clk_i);
      n = conv_cnt;
      axi_write(`CONVERSION_CLOCK_SELECT_OFF_CTRL, (chan << 4) | 1);
      // The bus stays idle while converting, as a sleeping core would.
      while (conv_cnt == n) @(posedge ref_clk_i);
   endtask

////////////////////////////////////////////////////////////////////////////////
   // Reset values of the registers.
   task automatic t_reset();
      axi_read(`CONVERSION_CLOCK_SELECT_OFF_TIMING);
      check(rd, 32'h0);
      axi_read(`CONVERSION_CLOCK_SELECT_OFF_STATUS);
      check(rd, 32'h0);
      axi_read(`CONVERSION_CLOCK_SELECT_OFF_MASK);
      check(rd, 32'h0);
      check(irq_o, 1'b0);
   endtask

   // Every clock-select code with zero acquisition, each on another channel.
   task automatic t_clocks();
      logic [31:0] res;
      for (int c = 0; c < 8; c++)
      begin
         // A steady comparator gives all ones or all zeros.
         comp_i <= c[0];
         res = c[0] ? 32'h3ff : 32'h0;
         convert(c, c + 8);
         check(dac_o, res);
         axi_read(`CONVERSION_CLOCK_SELECT_OFF_RESULT);
         check(rd, res);
         check(last_low, `CONVERSION_CLOCK_SELECT_BITS_PER_CONV * per(c));
         check(channel_o, c + 8);
         axi_read(`CONVERSION_CLOCK_SELECT_OFF_CTRL);
         check(rd[0], 1'b0);
         axi_read(`CONVERSION_CLOCK_SELECT_OFF_STATUS);
         check(rd, 32'h1);
         axi_write(`CONVERSION_CLOCK_SELECT_OFF_STATUS, 32'h1);
      end
   endtask

   // Programmed acquisition delays the start by whole bit periods.
   task automatic t_acq();
      int base;
      convert(1, 2);
      base = last_lead;
      for (int k = 1; k < 8; k += 3)
      begin
         convert((k << 3) | 1, 2);
         check(last_lead - base, k * per(1));
         check(last_low, `CONVERSION_CLOCK_SELECT_BITS_PER_CONV * per(1));
      end
   endtask

   // Go while busy is ignored, the done interrupt, then an abort.
   task automatic t_busy_abort();
      fork
         convert(6, 1);
         begin
            repeat (120) @(posedge ref_clk_i);
            axi_write(`CONVERSION_CLOCK_SELECT_OFF_CTRL, 32'h11);
         end
      join
      check(last_low, `CONVERSION_CLOCK_SELECT_BITS_PER_CONV * 64);
      check(irq_o, 1'b0);
      axi_write(`CONVERSION_CLOCK_SELECT_OFF_MASK, 32'h1);
      check(irq_o, 1'b1);
      axi_write(`CONVERSION_CLOCK_SELECT_OFF_STATUS, 32'h1);
      check(irq_o, 1'b0);
      axi_write(`CONVERSION_CLOCK_SELECT_OFF_CTRL, 32'h11);
      repeat (50) @(posedge ref_clk_i);
      axi_read(`CONVERSION_CLOCK_SELECT_OFF_CTRL);
      check(rd, 32'h11);
      axi_write(`CONVERSION_CLOCK_SELECT_OFF_CTRL, 32'h10);
      repeat (2) @(posedge ref_clk_i);
      check(sample_o, 1'b1);
      axi_read(`CONVERSION_CLOCK_SELECT_OFF_STATUS);
      check(rd, 32'h0);
      convert(0, 1);
      check(irq_o, 1'b1);
   endtask

   // Port reads mask analog pins; unmapped places are refused.
   task automatic t_port();
      pin_level_i <= 16'ha5a5;
      axi_write(`CONVERSION_CLOCK_SELECT_OFF_PINCFG, 32'h00ff);
      axi_read(`CONVERSION_CLOCK_SELECT_OFF_PORT);
      check(rd, 32'ha500);
      axi_read(8'h1c);
      check(resp, 2'b10);
      check(rd, 32'h0);
      axi_write(8'h20, 32'h1);
      check(resp, 2'b10);
   endtask

   // Main sequence.
   initial
   begin
      repeat (8) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      t_reset();
      t_clocks();
      t_acq();
      t_busy_abort();
      t_port();
      give_verdict();
   end
endmodule

`default_nettype wire
